// ==== rtl/epam_cfg.svh ====
`ifndef EPAM_CFG_SVH
`define EPAM_CFG_SVH
// saturation limits of the per-interval counters
`define EPAM_FLC_MAX 8'hFF
`define EPAM_FBE_MAX 10'h384
// seconds in one 15-minute interval
`define EPAM_IVL_SEC 10'h384
// one second in ns and the clock period in ns
`define EPAM_SEC_NS 1000000000
`define EPAM_CLK_NS 5
// intervals held by the 24-hour and 8-hour running totals
`define EPAM_DAY_IVLS 96
`define EPAM_PORT_IVLS 32
// bit positions in the status-event flag set
`define EPAM_EVF_RAI 0
`define EPAM_EVF_LOS 1
`define EPAM_EVF_EER 2
`define EPAM_EVF_FSB 3
`define EPAM_EVF_BPV 4
// alarm code of the first synchronous data port out-of-frame alarm
`define EPAM_ALM_PORT_BASE 15
`endif

// ==== rtl/epam_pkg.sv ====
package epam_pkg;
  // alarm codes, highest priority first
  typedef enum logic [4:0] {
    EPAM_LOS_LOOP1 = 5'h00, EPAM_LOS_LOOP2 = 5'h01, EPAM_LOS_DTE = 5'h02,
    EPAM_OOF_NET = 5'h03, EPAM_OOF_DTE = 5'h04, EPAM_AIS_NET = 5'h05, EPAM_AIS_DTE = 5'h06,
    EPAM_EER_NET = 5'h07, EPAM_EER_DTE = 5'h08, EPAM_RAI_NET = 5'h09, EPAM_RAI_DTE = 5'h0A,
    EPAM_LOMF_NET = 5'h0B, EPAM_LOMF_DTE = 5'h0C, EPAM_RMA_NET = 5'h0D, EPAM_RMA_DTE = 5'h0E
  } epam_alarm_t;
  // alarm reporter states
  typedef enum logic [3:0] {
    EPAM_IDLE = 4'h1,
    EPAM_SEND_SET = 4'h2,
    EPAM_HELD = 4'h4,
    EPAM_SEND_CLR = 4'h8
  } epam_state_t;
endpackage : epam_pkg

// ==== rtl/epam_window_sum.sv ====
`timescale 1ns/10ps
`include "epam_cfg.svh"
// running total of the last DEPTH interval values
module epam_window_sum import epam_pkg::*; #(
  parameter int unsigned DEPTH = `EPAM_DAY_IVLS,
  parameter int unsigned IW = 8,
  parameter int unsigned SW = 15
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  input wire logic clr,
  input wire logic push,
  input wire logic [IW-1:0] din,
  // total
  output logic [SW-1:0] sum_q
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  // DEPTH values below 2**IW each always fit in IW + clog2(DEPTH) bits
  if (SW < IW + $clog2(DEPTH)) begin : g_chk
    $error("epam_window_sum: SW too narrow for DEPTH");
  end

  logic [IW-1:0] mem [DEPTH]; // history; never reset, guarded by full_q
  logic [PW-1:0] ptr_q, ptr_d; // oldest slot, overwritten next
  logic full_q, full_d; // every slot holds a real interval
  logic [SW-1:0] sum_d;
  logic [IW-1:0] old_val; // value leaving the window

  // the old slot only counts once the window has wrapped, so no array reset is needed
  always_comb
  begin
    old_val = full_q ? mem[ptr_q] : '0;
    ptr_d = ptr_q;
    full_d = full_q;
    sum_d = sum_q;
    if (clr)
    begin
      ptr_d = '0;
      full_d = 1'b0;
      sum_d = '0;
    end
    else if (push)
    begin
      sum_d = SW'(sum_q + SW'(din) - SW'(old_val));
      ptr_d = (ptr_q == LAST) ? '0 : PW'(ptr_q + 1'b1);
      full_d = full_q | (ptr_q == LAST);
    end
  end

  // registers and history write
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ptr_q <= '0;
      full_q <= 1'b0;
      sum_q <= '0;
    end
    else
    begin
      ptr_q <= ptr_d;
      full_q <= full_d;
      sum_q <= sum_d;
    end
    if (push && !clr)
    begin
      mem[ptr_q] <= din;
    end
  end
endmodule : epam_window_sum

// ==== rtl/epam_monitor.sv ====
`timescale 1ns/10ps
`include "epam_cfg.svh"
//Contract
//- count frame-loss declarations, hold at 255
//- keep 24-hour and 8-hour frame-loss totals
//- no frame-loss count for loop sets
//- five sticky first-occurrence event flags per interval
//- report explicit none when no event seen
//- count loop far-end block errors up to 900
//- far stats complete only with 900 seconds
//- send alarm set and clear messages
//- every message carries customer identification
//- loss-of-signal alarms for loop1, loop2, DTE
//- six network and DTE alarm kinds
//- port out-of-frame and error-rate alarms
//- fixed alarm priority order, loss of signal first
//- simultaneous alarms: report only the higher one
//- suppress new alarms while reported one stands
//- alarm stays active while condition persists
//- clear message only when nothing remains active
//- clear command zeroes all counts and totals
module epam_monitor import epam_pkg::*; #(
  parameter int unsigned NUM_PORTS = 4,
  parameter int unsigned CYC_PER_SEC = `EPAM_SEC_NS / `EPAM_CLK_NS,
  parameter int unsigned CID_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // command and identity
  input wire logic clear_regs,
  input wire logic [CID_W-1:0] cust_id,
  // event strobes from the framers, one cycle each
  input wire logic net_frame_loss,
  input wire logic port_frame_loss,
  input wire logic [4:0] net_events,
  input wire logic [4:0] dte_events,
  input wire logic [1:0] loop_far_block_err,
  input wire logic far_second_rcvd,
  // alarm condition levels, one bit per alarm code
  input wire logic [`EPAM_ALM_PORT_BASE+2*NUM_PORTS-1:0] alarm_cond,
  // communications port handshake
  input wire logic msg_ready,
  // interval counts
  output logic [7:0] frame_loss_count_q,
  output logic [7:0] port_frame_loss_count_q,
  output logic [4:0] net_interval_event_flags_q,
  output logic [4:0] dte_interval_event_flags_q,
  output logic net_events_none_q,
  output logic dte_events_none_q,
  output logic [1:0][9:0] far_block_error_count_q,
  output logic far_complete_q,
  output logic [9:0] interval_seconds_q,
  output logic [6:0] valid_intervals_q,
  // running totals
  output logic [14:0] day_frame_loss_total_q,
  output logic [12:0] port_frame_loss_total_q,
  // alarm message
  output logic msg_valid_q,
  output logic msg_set_q,
  output logic [4:0] msg_code_q,
  output logic [CID_W-1:0] msg_cust_id_q
);
  localparam int unsigned NA = `EPAM_ALM_PORT_BASE + 2 * NUM_PORTS;
  localparam logic [27:0] PRESC_LAST = 28'(CYC_PER_SEC - 1);
  localparam logic [9:0] SEC_LAST = 10'(`EPAM_IVL_SEC - 1'b1);
  localparam logic [6:0] DAY_IVLS = 7'(`EPAM_DAY_IVLS);

  if (!(NUM_PORTS == 0 || NUM_PORTS == 2 || NUM_PORTS == 4)) begin : g_chk_ports
    $error("epam_monitor: NUM_PORTS must be 0, 2 or 4");
  end
  if (CYC_PER_SEC < 2 || CYC_PER_SEC > 28'hFFFFFFF) begin : g_chk_presc
    $error("epam_monitor: CYC_PER_SEC out of range");
  end

  // lowest code among the set bits wins
  function automatic logic [4:0] epam_pick(input logic [NA-1:0] v);
    logic [4:0] r;
    r = '0;
    for (int i = NA - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : epam_pick

  // interval timebase
  logic [27:0] presc_q, presc_d; // cycles within the second
  logic [9:0] sec_d;
  logic [6:0] valid_d;
  logic sec_tick; // last cycle of a second
  logic boundary; // last cycle of the interval

  always_comb
  begin
    sec_tick = (presc_q == PRESC_LAST);
    boundary = sec_tick && (interval_seconds_q == SEC_LAST);
    presc_d = sec_tick ? '0 : 28'(presc_q + 1'b1);
    sec_d = interval_seconds_q;
    valid_d = valid_intervals_q;
    if (clear_regs)
    begin
      presc_d = '0;
      sec_d = '0;
      valid_d = '0;
    end
    else if (boundary)
    begin
      sec_d = '0;
      valid_d = (valid_intervals_q == DAY_IVLS) ? DAY_IVLS : 7'(valid_intervals_q + 1'b1);
    end
    else if (sec_tick)
    begin
      sec_d = 10'(interval_seconds_q + 1'b1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      presc_q <= '0;
      interval_seconds_q <= '0;
      valid_intervals_q <= '0;
    end
    else
    begin
      presc_q <= presc_d;
      interval_seconds_q <= sec_d;
      valid_intervals_q <= valid_d;
    end
  end

  // per-interval counters and sticky flags; an event in the boundary cycle opens the new interval, a far-end second closes the old one
  logic [7:0] flc_d, pflc_d;
  logic [4:0] nflg_d, dflg_d;
  logic [1:0][9:0] fbe_d;
  logic [9:0] far_cnt_q, far_cnt_d; // far-end seconds received this interval
  logic [9:0] far_cnt_inc;
  logic fcmp_d;

  always_comb
  begin
    far_cnt_inc = (far_second_rcvd && far_cnt_q != `EPAM_IVL_SEC) ? 10'(far_cnt_q + 1'b1) : far_cnt_q;
    flc_d = boundary ? 8'(net_frame_loss) : frame_loss_count_q;
    if (!boundary && net_frame_loss && frame_loss_count_q != `EPAM_FLC_MAX)
    begin
      flc_d = 8'(frame_loss_count_q + 1'b1);
    end
    pflc_d = boundary ? 8'(port_frame_loss) : port_frame_loss_count_q;
    if (!boundary && port_frame_loss && port_frame_loss_count_q != `EPAM_FLC_MAX)
    begin
      pflc_d = 8'(port_frame_loss_count_q + 1'b1);
    end
    // flags exist only for the network and DTE sets
    nflg_d = boundary ? net_events : (net_interval_event_flags_q | net_events);
    dflg_d = boundary ? dte_events : (dte_interval_event_flags_q | dte_events);
    for (int l = 0; l < 2; l++)
    begin
      fbe_d[l] = boundary ? 10'(loop_far_block_err[l]) : far_block_error_count_q[l];
      if (!boundary && loop_far_block_err[l] && far_block_error_count_q[l] != `EPAM_FBE_MAX)
      begin
        fbe_d[l] = 10'(far_block_error_count_q[l] + 1'b1);
      end
    end
    // a second arriving in the boundary cycle still belongs to the closing interval
    far_cnt_d = boundary ? '0 : far_cnt_inc;
    fcmp_d = boundary ? (far_cnt_inc == `EPAM_IVL_SEC) : far_complete_q;
    if (clear_regs)
    begin
      flc_d = '0;
      pflc_d = '0;
      nflg_d = '0;
      dflg_d = '0;
      fbe_d = '0;
      far_cnt_d = '0;
      fcmp_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      frame_loss_count_q <= '0;
      port_frame_loss_count_q <= '0;
      net_interval_event_flags_q <= '0;
      dte_interval_event_flags_q <= '0;
      net_events_none_q <= 1'b1;
      dte_events_none_q <= 1'b1;
      far_block_error_count_q <= '0;
      far_cnt_q <= '0;
      far_complete_q <= 1'b0;
    end
    else
    begin
      frame_loss_count_q <= flc_d;
      port_frame_loss_count_q <= pflc_d;
      net_interval_event_flags_q <= nflg_d;
      dte_interval_event_flags_q <= dflg_d;
      net_events_none_q <= ~|nflg_d;
      dte_events_none_q <= ~|dflg_d;
      far_block_error_count_q <= fbe_d;
      far_cnt_q <= far_cnt_d;
      far_complete_q <= fcmp_d;
    end
  end

  // loops carry no frame-loss count: only network and port counts feed the totals
  // the totals take the closing count, not the value that opens the next interval
  epam_window_sum #(.DEPTH(`EPAM_DAY_IVLS), .IW(8), .SW(15)) u_day_total (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clr(clear_regs),
    .push(boundary),
    .din(frame_loss_count_q),
    .sum_q(day_frame_loss_total_q)
  );
  epam_window_sum #(.DEPTH(`EPAM_PORT_IVLS), .IW(8), .SW(13)) u_port_total (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clr(clear_regs),
    .push(boundary),
    .din(port_frame_loss_count_q),
    .sum_q(port_frame_loss_total_q)
  );

  // alarm reporter; alarm_cond carries the loop, network, DTE and port codes in priority order
  epam_state_t st_q, st_d;
  logic [NA-1:0] cond_q; // previous levels, for onset detection
  logic [NA-1:0] rise;
  logic mv_d, ms_d;
  logic [4:0] mc_d;
  logic [CID_W-1:0] mid_d;

  always_comb
  begin
    rise = alarm_cond & ~cond_q;
    st_d = st_q;
    mv_d = msg_valid_q;
    ms_d = msg_set_q;
    mc_d = msg_code_q;
    mid_d = msg_cust_id_q;
    unique case (st_q)
      EPAM_IDLE:
      begin
        if (|rise)
        begin
          // onsets seen while another alarm is held are dropped, not queued
          mc_d = epam_pick(rise);
          ms_d = 1'b1;
          mv_d = 1'b1;
          mid_d = cust_id;
          st_d = EPAM_SEND_SET;
        end
      end
      EPAM_SEND_SET:
      begin
        if (msg_ready)
        begin
          mv_d = 1'b0;
          st_d = EPAM_HELD;
        end
      end
      EPAM_HELD:
      begin
        // stay here while the reported condition persists; new onsets are ignored
        if (!alarm_cond[msg_code_q])
        begin
          if (alarm_cond == '0)
          begin
            ms_d = 1'b0;
            mv_d = 1'b1;
            mid_d = cust_id;
            st_d = EPAM_SEND_CLR;
          end
          else
          begin
            st_d = EPAM_IDLE;
          end
        end
      end
      EPAM_SEND_CLR:
      begin
        if (msg_ready)
        begin
          mv_d = 1'b0;
          st_d = EPAM_IDLE;
        end
      end
      default:
      begin
        st_d = EPAM_IDLE;
        mv_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_q <= EPAM_IDLE;
      cond_q <= '0;
      msg_valid_q <= 1'b0;
      msg_set_q <= 1'b0;
      msg_code_q <= '0;
      msg_cust_id_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cond_q <= alarm_cond;
      msg_valid_q <= mv_d;
      msg_set_q <= ms_d;
      msg_code_q <= mc_d;
      msg_cust_id_q <= mid_d;
    end
  end

  // checks
  sequence s_held_new;
    st_q == EPAM_HELD && alarm_cond[msg_code_q] && (|rise);
  endsequence
  sequence s_no_msg;
    !msg_valid_q [*2];
  endsequence

  property p_flc_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    frame_loss_count_q == `EPAM_FLC_MAX && !boundary && !clear_regs |=> frame_loss_count_q == `EPAM_FLC_MAX;
  endproperty
  a_flc_hold: assert property (p_flc_hold) else $error("frame loss count left its ceiling");

  property p_flc_inc;
    @(posedge sys_clk) disable iff (sys_rst)
    net_frame_loss && !boundary && !clear_regs && frame_loss_count_q < 8'hFF
      |=> frame_loss_count_q == 8'($past(frame_loss_count_q) + 1'b1);
  endproperty
  a_flc_inc: assert property (p_flc_inc) else $error("frame loss not counted");

  property p_flag_sticky;
    @(posedge sys_clk) disable iff (sys_rst)
    net_interval_event_flags_q[`EPAM_EVF_LOS] && !boundary && !clear_regs
      |=> net_interval_event_flags_q[`EPAM_EVF_LOS];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("event flag dropped mid interval");

  property p_none;
    @(posedge sys_clk) disable iff (sys_rst)
    ##1 (net_events_none_q == (net_interval_event_flags_q == 5'h00));
  endproperty
  a_none: assert property (p_none) else $error("none status disagrees with flags");

  property p_fbe_cap;
    @(posedge sys_clk) disable iff (sys_rst)
    ##1 (far_block_error_count_q[0] <= `EPAM_FBE_MAX && far_block_error_count_q[1] <= `EPAM_FBE_MAX);
  endproperty
  a_fbe_cap: assert property (p_fbe_cap) else $error("far block error count above ceiling");

  property p_complete;
    @(posedge sys_clk) disable iff (sys_rst)
    boundary && !clear_regs |=> far_complete_q == ($past(far_cnt_inc) == `EPAM_IVL_SEC);
  endproperty
  a_complete: assert property (p_complete) else $error("far complete flag wrong");

  property p_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    clear_regs |=> frame_loss_count_q == 8'h00 && interval_seconds_q == 10'h000 && valid_intervals_q == 7'h00
      ##1 day_frame_loss_total_q == 15'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear command left state behind");

  property p_suppress;
    @(posedge sys_clk) disable iff (sys_rst)
    s_held_new |=> s_no_msg;
  endproperty
  a_suppress: assert property (p_suppress) else $error("alarm reported while another is held");

  property p_clr_only_idle;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(msg_valid_q) && !msg_set_q |-> $past(alarm_cond) == '0;
  endproperty
  a_clr_only_idle: assert property (p_clr_only_idle) else $error("clear sent with alarms active");

  property p_prio;
    @(posedge sys_clk) disable iff (sys_rst)
    st_q == EPAM_IDLE && rise[0] |=> msg_valid_q && msg_set_q && msg_code_q == 5'h00 && msg_cust_id_q == $past(cust_id);
  endproperty
  a_prio: assert property (p_prio) else $error("top priority onset not reported");
endmodule : epam_monitor

// ==== tb/epam_term_model.sv ====
`timescale 1ns/10ps
// terminal on the comm port: accepts one alarm message at a time
module epam_term_model #(
  parameter int unsigned CID_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // message from the block
  input wire logic msg_valid_q,
  input wire logic msg_set_q,
  input wire logic [4:0] msg_code_q,
  input wire logic [CID_W-1:0] msg_cust_id_q,
  // stall length chosen by the bench, 0 = prompt
  input wire logic [2:0] stall,
  // handshake and captured message
  output logic msg_ready,
  output logic got_q,
  output logic [CID_W+5:0] got_msg_q
);
  logic [2:0] wait_q; // cycles the pending message has waited

  // a slow printer holds ready low until its stall has run out
  assign msg_ready = msg_valid_q && (wait_q >= stall);

  // take the whole message at the accepting edge, then wait for the next
  always_ff @(posedge sys_clk)
  begin
    got_q <= 1'b0;
    if (sys_rst)
      wait_q <= 3'h0;
    else if (msg_valid_q && msg_ready)
    begin
      got_q <= 1'b1;
      got_msg_q <= {msg_set_q, msg_code_q, msg_cust_id_q};
      wait_q <= 3'h0;
    end
    else if (msg_valid_q && wait_q != 3'h7)
      wait_q <= wait_q + 3'h1;
  end
endmodule : epam_term_model

// ==== tb/test_epam_monitor.sv ====
`timescale 1ns/10ps
// bench: counters compared in place, alarm messages through a queue
module test_epam_monitor;
  localparam int NP = 2; // two synchronous data ports
  localparam int AW = 15 + 2 * NP; // alarm condition width
  // stimulus, all given a value at time zero
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clear_regs = 1'b0;
  logic [7:0] cust_id = 8'h00;
  logic net_frame_loss = 1'b0;
  logic port_frame_loss = 1'b0;
  logic [4:0] net_events = 5'h00;
  logic [4:0] dte_events = 5'h00;
  logic [1:0] loop_far_block_err = 2'h0;
  logic far_second_rcvd = 1'b0;
  logic [AW-1:0] alarm_cond = '0;
  logic [2:0] stall = 3'h0;
  // observed outputs
  logic msg_ready, nnone, dnone, fcomp, mvalid, mset, got;
  logic [7:0] flc, pflc, mcid;
  logic [4:0] nflag, dflag, mcode;
  logic [1:0][9:0] fbe;
  logic [9:0] isec;
  logic [6:0] vint;
  logic [14:0] dtot;
  logic [12:0] ptot;
  logic [13:0] gmsg;
  // bench bookkeeping
  int seed = 32'hEF57;
  int num_errors = 0;
  int comparisons = 0;
  int pcnt, l1cnt;
  logic [4:0] m1, m2, m3;
  logic [13:0] exp_q[$]; // expected {set, code, id}, oldest first

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // short seconds keep a 900-second interval near 3600 cycles
  epam_monitor #(.NUM_PORTS(NP), .CYC_PER_SEC(4), .CID_W(8)) u_epam_monitor (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clear_regs(clear_regs), .cust_id(cust_id),
    .net_frame_loss(net_frame_loss), .port_frame_loss(port_frame_loss),
    .net_events(net_events), .dte_events(dte_events),
    .loop_far_block_err(loop_far_block_err), .far_second_rcvd(far_second_rcvd),
    .alarm_cond(alarm_cond), .msg_ready(msg_ready), .frame_loss_count_q(flc),
    .port_frame_loss_count_q(pflc), .net_interval_event_flags_q(nflag),
    .dte_interval_event_flags_q(dflag), .net_events_none_q(nnone), .dte_events_none_q(dnone),
    .far_block_error_count_q(fbe), .far_complete_q(fcomp), .interval_seconds_q(isec),
    .valid_intervals_q(vint), .day_frame_loss_total_q(dtot), .port_frame_loss_total_q(ptot),
    .msg_valid_q(mvalid), .msg_set_q(mset), .msg_code_q(mcode), .msg_cust_id_q(mcid));

  epam_term_model #(.CID_W(8)) u_epam_term_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .msg_valid_q(mvalid), .msg_set_q(mset),
    .msg_code_q(mcode), .msg_cust_id_q(mcid), .stall(stall), .msg_ready(msg_ready),
    .got_q(got), .got_msg_q(gmsg));

  // one compare, counted; mismatch reported at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  // wait, bounded, until every expected message has arrived
  task automatic drain();
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 60)
    begin
      tick(1);
      k++;
    end
    check(32'(exp_q.size()), 32'h0, "alarm message missing");
    tick(3);
  endtask : drain

  // raise conditions c, expect a set for code, drop all, expect its clear
  task automatic alm(input logic [AW-1:0] c, input logic [4:0] code);
    cust_id = 8'($random(seed));
    stall = 3'($random(seed)) & 3'h3;
    exp_q.push_back({1'b1, code, cust_id});
    alarm_cond = c;
    drain();
    tick(4);
    exp_q.push_back({1'b0, code, cust_id});
    alarm_cond = '0;
    drain();
  endtask : alm

  // ride to the edge where the seconds count wraps from 899 to 0
  task automatic to_boundary();
    int k;
    k = 0;
    while (isec !== 10'h383 && k < 4000)
    begin
      tick(1);
      k++;
    end
    while (isec !== 10'h000 && k < 4000)
    begin
      tick(1);
      k++;
    end
    check(32'(k < 4000), 32'h1, "interval boundary not reached");
  endtask : to_boundary

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // every accepted message is matched against the oldest note
  always @(posedge sys_clk)
  begin
    if (got)
    begin
      if (exp_q.size() == 0)
        check(32'(gmsg), 32'hFFFFFFFF, "message with none expected");
      else
        check(32'(gmsg), 32'(exp_q.pop_front()), "alarm message");
    end
  end

  // watchdog, well past the expected run of about 7200 cycles
  initial
  begin
    #100000;
    num_errors++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    tick(8);
    sys_rst = 1'b0;
    tick(2);
    clear_regs = 1'b1;
    tick(1);
    clear_regs = 1'b0;
    m1 = 5'($random(seed));
    m2 = 5'($random(seed));
    m3 = 5'($random(seed));
    pcnt = 0;
    l1cnt = 0;
    // back-to-back strobes drive the network frame-loss and loop1 counters past their ceilings
    for (int i = 0; i < 905; i++)
    begin
      net_frame_loss = (i < 260);
      port_frame_loss = 1'($random(seed));
      pcnt += port_frame_loss;
      loop_far_block_err = {1'($random(seed)), 1'b1};
      l1cnt += loop_far_block_err[1];
      far_second_rcvd = (i < 900);
      net_events = (i == 5) ? m1 : ((i == 9) ? m2 : 5'h00);
      dte_events = (i == 7) ? m3 : 5'h00;
      tick(1);
    end
    {net_frame_loss, port_frame_loss, loop_far_block_err, far_second_rcvd} = 5'h00;
    net_events = 5'h00;
    dte_events = 5'h00;
    tick(1);
    if (pcnt > 255)
      pcnt = 255;
    if (l1cnt > 900)
      l1cnt = 900;
    check(32'(flc), 32'hFF, "frame loss count");
    check(32'(pflc), 32'(pcnt), "port frame loss count");
    check(32'(nflag), 32'(m1 | m2), "net event flags");
    check(32'(nnone), 32'((m1 | m2) == 5'h00), "net none");
    check(32'(dflag), 32'(m3), "dte event flags");
    check(32'(dnone), 32'(m3 == 5'h00), "dte none");
    check(32'(fbe[0]), 32'h384, "loop1 far block errors");
    check(32'(fbe[1]), 32'(l1cnt), "loop2 far block errors");
    // simultaneous onsets: only the higher; later onsets stay silent
    cust_id = 8'($random(seed));
    stall = 3'h2;
    exp_q.push_back({1'b1, 5'h05, cust_id});
    alarm_cond = (AW'(1) << 5) | (AW'(1) << 9);
    drain();
    alarm_cond[0] = 1'b1;
    tick(6);
    alarm_cond[5] = 1'b0;
    tick(6);
    alarm_cond = '0;
    tick(10);
    drain();
    // each code but the last with its lower-priority neighbour, the last code alone, prompt and slow terminal
    for (int c = 0; c < AW; c++)
      alm(AW'(3) << c, 5'(c));
    to_boundary();
    check(32'(flc), 32'h0, "count after boundary");
    check(32'({nflag, dflag, fbe}), 32'h0, "flags after boundary");
    check(32'({nnone, dnone}), 32'h3, "none after boundary");
    check(32'(fcomp), 32'h1, "complete with 900 seconds");
    check(32'(vint), 32'h1, "valid intervals");
    check(32'(dtot), 32'hFF, "day frame loss total");
    check(32'(ptot), 32'(pcnt), "port frame loss total");
    // one far second short of a full interval
    far_second_rcvd = 1'b1;
    tick(899);
    far_second_rcvd = 1'b0;
    to_boundary();
    check(32'(fcomp), 32'h0, "complete with 899 seconds");
    check(32'(dtot), 32'hFF, "day total over two intervals");
    // clear command in the middle of counting
    net_frame_loss = 1'b1;
    tick(3);
    net_frame_loss = 1'b0;
    clear_regs = 1'b1;
    tick(1);
    clear_regs = 1'b0;
    check(32'({flc, isec, vint}), 32'h0, "counts after clear");
    check(32'({dtot, ptot}), 32'h0, "totals after clear");
    wrap_up();
  end
endmodule : test_epam_monitor
